//--- hw/ocd_channel_ctrl.v
// Output channel divider control: registers, integer divider, alignment, mute and output shaping
`include "ocd_consts.vh"

// Functional notes
// - Low fraction bits 8-0, reset zero
// - High fraction 16 bits, reset 8000h, above
// - Fraction doubles as delay setting
// - Delay select: 0 synthesis, 1 delay
// - Bits 15-14 pick integer divider source
// - Divide by bits 13-0; zero powers down
// - Alignment delay counts source cycles, bits 15-11
// - Bit 10 enables alignment participation
// - Mute level select sets leg levels
// - Override mutes directly, else calibration mute
// - Bits 6-5 set single-ended leg polarity
// - Bits 4-2 choose output buffer format
// - Bits 1-0 choose routed channel clock
// - Smooth switch applies changes at boundary
module ocd_channel_ctrl #(
  parameter DIV_WIDTH   = 14,
  parameter DELAY_WIDTH = 5
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Register access
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [15:0] regRdData,
  // Source clocks and alignment request from outside the domain
  input  wire        prescalerA,
  input  wire        prescalerB,
  input  wire        fracDivClk,
  input  wire        refClk,
  input  wire        channel1Clk,
  input  wire        channel3Clk,
  input  wire        alignRequest,
  // Same-domain controls
  input  wire        outputOverride,
  input  wire        calibrationActive,
  // Fractional divider setup
  output reg  [24:0] fracSynthWord,
  output reg  [24:0] fracDelayWord,
  output reg         fracDelayMode,
  // Output buffer
  output reg  [2:0]  outputFormat,
  output reg         outP,
  output reg         outN,
  output reg         outPEnable,
  output reg         outNEnable,
  output reg         muteActive,
  output reg         dividerPoweredDown,
  output reg         aligning
);
  localparam ALIGN_IDLE = 1'b0;
  localparam ALIGN_WAIT = 1'b1;

  reg [15:0] fracHighReg;
  reg [15:0] fracLowReg;
  reg [15:0] intDivReg;
  reg [15:0] formatReg;
  reg [15:0] modeReg;

  reg [DIV_WIDTH-1:0]   activeDiv;
  reg [1:0]             activeSel;
  reg [DIV_WIDTH-1:0]   divCount;
  reg [DELAY_WIDTH-1:0] delayCount;
  reg                   alignState;
  reg                   divOut;

  wire [3:0] syncLevel;
  wire [3:0] syncRise;
  wire       alignPulse;
  wire       ch1Level;
  wire       ch3Level;

  wire [DIV_WIDTH-1:0]   newDiv       = intDivReg[`OCD_DIV_MSB:0];
  wire [1:0]             newSel       = intDivReg[`OCD_SRC_SEL_MSB:`OCD_SRC_SEL_LSB];
  wire [DELAY_WIDTH-1:0] alignDelay   = formatReg[`OCD_ALIGN_DLY_MSB:`OCD_ALIGN_DLY_LSB];
  wire                   alignEnable  = formatReg[`OCD_ALIGN_EN_BIT];
  wire                   muteLevelSel = formatReg[`OCD_MUTE_LVL_BIT];
  wire                   silence      = formatReg[`OCD_SILENCE_BIT];
  wire [1:0]             polarity     = formatReg[`OCD_POL_MSB:`OCD_POL_LSB];
  wire [2:0]             fmtSel       = formatReg[`OCD_FMT_MSB:`OCD_FMT_LSB];
  wire [1:0]             outSrcSel    = formatReg[`OCD_OSRC_MSB:0];
  wire                   smoothSwitch = modeReg[`OCD_SMOOTH_BIT];
  wire [24:0]            fracWord     = {fracHighReg, fracLowReg[`OCD_FRAC_LOW_MSB:0]};

  function pickBit;
    input [1:0] sel;
    input [3:0] bits;
    begin
      pickBit = bits[sel];
    end
  endfunction

  ocd_edge_sync uSyncA (.clk_sys(clk_sys), .rst(rst), .asyncIn(prescalerA), .level(syncLevel[0]), .rise(syncRise[0]));
  ocd_edge_sync uSyncB (.clk_sys(clk_sys), .rst(rst), .asyncIn(prescalerB), .level(syncLevel[1]), .rise(syncRise[1]));
  ocd_edge_sync uSyncF (.clk_sys(clk_sys), .rst(rst), .asyncIn(fracDivClk), .level(syncLevel[2]), .rise(syncRise[2]));
  ocd_edge_sync uSyncR (.clk_sys(clk_sys), .rst(rst), .asyncIn(refClk), .level(syncLevel[3]), .rise(syncRise[3]));
  ocd_edge_sync uSyncAl (.clk_sys(clk_sys), .rst(rst), .asyncIn(alignRequest), .level(), .rise(alignPulse));
  ocd_edge_sync uSync1 (.clk_sys(clk_sys), .rst(rst), .asyncIn(channel1Clk), .level(ch1Level), .rise());
  ocd_edge_sync uSync3 (.clk_sys(clk_sys), .rst(rst), .asyncIn(channel3Clk), .level(ch3Level), .rise());
  wire srcEdge  = pickBit(activeSel, syncRise[3:0]);
  wire srcLevel = pickBit(activeSel, syncLevel[3:0]);
  wire atWrap   = srcEdge && (divCount == activeDiv - 1'b1);

  // Register file; every bit is stored and read back
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fracHighReg <= `OCD_RST_FRAC_HIGH;
      fracLowReg  <= `OCD_RST_FRAC_LOW;
      intDivReg   <= `OCD_RST_INT_DIV;
      formatReg   <= `OCD_RST_FORMAT;
      modeReg     <= `OCD_RST_MODE;
      regRdData   <= 16'h0000;
    end else begin
      if (regWrite) begin
        case (regAddr)
          `OCD_ADDR_FRAC_HIGH: fracHighReg <= regWrData;
          `OCD_ADDR_FRAC_LOW:  fracLowReg  <= regWrData;
          `OCD_ADDR_INT_DIV:   intDivReg   <= regWrData;
          `OCD_ADDR_FORMAT:    formatReg   <= regWrData;
          `OCD_ADDR_MODE:      modeReg     <= regWrData;
          default:             fracLowReg  <= fracLowReg;
        endcase
      end
      if (regRead) begin
        case (regAddr)
          `OCD_ADDR_FRAC_HIGH: regRdData <= fracHighReg;
          `OCD_ADDR_FRAC_LOW:  regRdData <= fracLowReg;
          `OCD_ADDR_INT_DIV:   regRdData <= intDivReg;
          `OCD_ADDR_FORMAT:    regRdData <= formatReg;
          `OCD_ADDR_MODE:      regRdData <= modeReg;
          default:             regRdData <= 16'h0000;
        endcase
      end
    end
  end

  // Integer divider with source switching and alignment hold
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      activeDiv  <= {DIV_WIDTH{1'b0}};
      activeSel  <= 2'h0;
      divCount   <= {DIV_WIDTH{1'b0}};
      delayCount <= {DELAY_WIDTH{1'b0}};
      alignState <= ALIGN_IDLE;
      divOut     <= 1'b0;
    end else begin
      // Immediate mode or a stopped divider takes new settings at once
      if (!smoothSwitch || activeDiv == {DIV_WIDTH{1'b0}} || atWrap) begin
        activeDiv <= newDiv;
        activeSel <= newSel;
      end
      case (alignState)
        ALIGN_IDLE: begin
          if (alignPulse && alignEnable) begin
            divCount <= {DIV_WIDTH{1'b0}};
            divOut   <= 1'b0;
            if (alignDelay != {DELAY_WIDTH{1'b0}}) begin
              delayCount <= alignDelay;
              alignState <= ALIGN_WAIT;
            end
          end else if (activeDiv == {DIV_WIDTH{1'b0}}) begin
            divCount <= {DIV_WIDTH{1'b0}};
            divOut   <= 1'b0;
          end else begin
            if (srcEdge) begin
              divCount <= atWrap ? {DIV_WIDTH{1'b0}} : divCount + 1'b1;
            end
            if (activeDiv == {{(DIV_WIDTH-1){1'b0}}, 1'b1}) begin
              divOut <= srcLevel;
            end else begin
              divOut <= (divCount < (activeDiv >> 1));
            end
          end
        end
        ALIGN_WAIT: begin
          divOut <= 1'b0;
          if (srcEdge) begin
            delayCount <= delayCount - 1'b1;
            if (delayCount == {{(DELAY_WIDTH-1){1'b0}}, 1'b1}) begin
              alignState <= ALIGN_IDLE;
            end
          end
        end
        default: alignState <= ALIGN_IDLE;
      endcase
    end
  end

  // Output selection, mute, polarity and format
  reg routedClk;
  reg muteNow;
  reg nextP;
  reg nextN;
  reg nextPEn;
  reg nextNEn;
  always @* begin
    case (outSrcSel)
      2'h0:    routedClk = ch1Level;
      2'h1:    routedClk = divOut;
      2'h2:    routedClk = ch3Level;
      default: routedClk = 1'b0;
    endcase
    muteNow = outputOverride ? silence : (silence & calibrationActive);
    nextPEn = (fmtSel != `OCD_FMT_OFF) && (fmtSel != `OCD_FMT_SE_NEG);
    nextNEn = (fmtSel != `OCD_FMT_OFF) && (fmtSel != `OCD_FMT_SE_POS);
    if (muteNow) begin
      nextP = muteLevelSel;
      nextN = ~muteLevelSel;
    end else if (fmtSel >= `OCD_FMT_SE_BOTH) begin
      nextP = routedClk ^ polarity[1];
      nextN = routedClk ^ polarity[0];
    end else begin
      nextP = routedClk;
      nextN = ~routedClk;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fracSynthWord      <= 25'h000_0000;
      fracDelayWord      <= 25'h000_0000;
      fracDelayMode      <= 1'b0;
      outputFormat       <= 3'h0;
      outP               <= 1'b0;
      outN               <= 1'b0;
      outPEnable         <= 1'b0;
      outNEnable         <= 1'b0;
      muteActive         <= 1'b0;
      dividerPoweredDown <= 1'b1;
      aligning           <= 1'b0;
    end else begin
      fracDelayMode      <= modeReg[`OCD_DELAY_MODE_BIT];
      fracSynthWord      <= modeReg[`OCD_DELAY_MODE_BIT] ? 25'h000_0000 : fracWord;
      fracDelayWord      <= modeReg[`OCD_DELAY_MODE_BIT] ? fracWord : 25'h000_0000;
      outputFormat       <= fmtSel;
      outP               <= nextP;
      outN               <= nextN;
      outPEnable         <= nextPEn;
      outNEnable         <= nextNEn;
      muteActive         <= muteNow;
      dividerPoweredDown <= (activeDiv == {DIV_WIDTH{1'b0}});
      aligning           <= (alignState == ALIGN_WAIT);
    end
  end
endmodule // ocd_channel_ctrl

//--- hw/ocd_consts.vh
// Register offsets, field positions, reset values for the output channel divider control
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH
`define OCD_ADDR_FRAC_HIGH   8'h29
`define OCD_ADDR_FRAC_LOW    8'h2A
`define OCD_ADDR_INT_DIV     8'h2B
`define OCD_ADDR_FORMAT      8'h2C
`define OCD_ADDR_MODE        8'h2D
`define OCD_RST_FRAC_HIGH    16'h8000
`define OCD_RST_FRAC_LOW     16'h0000
`define OCD_RST_INT_DIV      16'h0000
`define OCD_RST_FORMAT       16'h0008
`define OCD_RST_MODE         16'h0071
`define OCD_FRAC_LOW_MSB     8
`define OCD_SRC_SEL_MSB      15
`define OCD_SRC_SEL_LSB      14
`define OCD_DIV_MSB          13
`define OCD_ALIGN_DLY_MSB    15
`define OCD_ALIGN_DLY_LSB    11
`define OCD_ALIGN_EN_BIT     10
`define OCD_MUTE_LVL_BIT     8
`define OCD_SILENCE_BIT      7
`define OCD_POL_MSB          6
`define OCD_POL_LSB          5
`define OCD_FMT_MSB          4
`define OCD_FMT_LSB          2
`define OCD_OSRC_MSB         1
`define OCD_DELAY_MODE_BIT   15
`define OCD_SMOOTH_BIT       0
`define OCD_FMT_OFF          3'h0
`define OCD_FMT_SE_BOTH      3'h5
`define OCD_FMT_SE_POS       3'h6
`define OCD_FMT_SE_NEG       3'h7
`endif

//--- hw/ocd_edge_sync.v
// Three-stage synchroniser with rising-edge pulse for an external clock or pin
module ocd_edge_sync (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Asynchronous input
  input  wire asyncIn,
  // Synchronised level and rising-edge pulse
  output reg  level,
  output reg  rise
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
      rise   <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      rise   <= 1'b0;
      // A change counts only once stages two and three agree
      if (stage2 == stage3) begin
        level <= stage3;
        rise  <= stage3 & ~level;
      end
    end
  end
endmodule // ocd_edge_sync

//--- verification/ocd_channel_ctrl_props.sv
// Checker properties for the output channel divider control
module ocd_channel_ctrl_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register writes and mute controls
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        outputOverride,
  input wire logic        calibrationActive,
  // Outputs under check
  input wire logic [24:0] fracSynthWord,
  input wire logic [24:0] fracDelayWord,
  input wire logic        fracDelayMode,
  input wire logic [2:0]  outputFormat,
  input wire logic        outPEnable,
  input wire logic        outNEnable,
  input wire logic        muteActive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_synth_zero; fracDelayMode |-> fracSynthWord == 25'h000_0000; endproperty
  a_synth_zero: assert property (p_synth_zero) else $error("synthesis word live in delay mode");
  property p_delay_zero; !fracDelayMode |-> fracDelayWord == 25'h000_0000; endproperty
  a_delay_zero: assert property (p_delay_zero) else $error("delay word live in synthesis mode");
  property p_high; regWrite && regAddr == 8'h29 ##2 !fracDelayMode |-> fracSynthWord[24:9] == $past(regWrData, 2);
  endproperty
  a_high: assert property (p_high) else $error("upper fraction not applied");
  property p_low; regWrite && regAddr == 8'h2A ##2 !fracDelayMode
    |-> {7'h00, fracSynthWord[8:0]} == ($past(regWrData, 2) & 16'h01FF); endproperty
  a_low: assert property (p_low) else $error("lower fraction not applied");
  property p_mode; regWrite && regAddr == 8'h2D |-> ##2 {15'h0000, fracDelayMode} == ($past(regWrData, 2) >> 15);
  endproperty
  a_mode: assert property (p_mode) else $error("delay select not applied");
  property p_fmt; regWrite && regAddr == 8'h2C
    |-> ##2 {13'h0000, outputFormat} == (($past(regWrData, 2) >> 2) & 16'h0007); endproperty
  a_fmt: assert property (p_fmt) else $error("format not applied");
  property p_ena; outPEnable == (outputFormat != 3'h0 && outputFormat != 3'h7)
    && outNEnable == (outputFormat != 3'h0 && outputFormat != 3'h6); endproperty
  a_ena: assert property (p_ena) else $error("leg enables disagree with format");
  property p_mute_off; (!outputOverride && !calibrationActive) [*2] |-> !muteActive; endproperty
  a_mute_off: assert property (p_mute_off) else $error("mute without override or calibration");
endmodule // ocd_channel_ctrl_props

bind ocd_channel_ctrl ocd_channel_ctrl_props u_props (.clk_sys, .rst, .regAddr, .regWrData, .regWrite,
  .outputOverride, .calibrationActive, .fracSynthWord, .fracDelayWord, .fracDelayMode, .outputFormat,
  .outPEnable, .outNEnable, .muteActive);

//--- verification/tb.sv
// Self-checking testbench for the output channel divider control
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} ocd_row_t;
  logic        clk_sys, rst, regWrite, regRead, refClk, channel1Clk, alignRequest;
  logic        outputOverride, calibrationActive, fracDelayMode, outP, outN, outPEnable, outNEnable;
  logic        muteActive, dividerPoweredDown, aligning;
  logic        prescalerA, prescalerB, fracDivClk, channel3Clk;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, rdv;
  logic [24:0] fracSynthWord, fracDelayWord;
  logic [2:0]  outputFormat;
  int          err_total, checked, hiCnt, riseCnt;
  ocd_row_t    rows [10] = '{'{1'b0, 8'h29, 16'h0000, 16'h8000}, '{1'b0, 8'h2A, 16'h0000, 16'h0000},
    '{1'b0, 8'h2B, 16'h0000, 16'h0000}, '{1'b0, 8'h2C, 16'h0000, 16'h0008}, '{1'b0, 8'h2D, 16'h0000, 16'h0071},
    '{1'b1, 8'h2A, 16'hFFFF, 16'hFFFF}, '{1'b1, 8'h2C, 16'h0200, 16'h0200}, '{1'b1, 8'h2E, 16'h1234, 16'h0000},
    '{1'b1, 8'h29, 16'hABCD, 16'hABCD}, '{1'b1, 8'h2B, 16'h0000, 16'h0000}};
  ocd_channel_ctrl u_dut (.clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .prescalerA, .prescalerB, .fracDivClk, .refClk, .channel1Clk, .channel3Clk,
    .alignRequest, .outputOverride, .calibrationActive, .fracSynthWord, .fracDelayWord, .fracDelayMode,
    .outputFormat, .outP, .outN, .outPEnable, .outNEnable, .muteActive, .dividerPoweredDown, .aligning);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Reference source toggles just after a clock edge, period of 16 clocks
  initial begin
    refClk = 1'b0;
    forever begin
      repeat (8) @(posedge clk_sys);
      #1 refClk = ~refClk;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    tick(1);
    regWrite = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    regRead = 1'b1;
    tick(1);
    regRead = 1'b0;
    tick(1);
    rdv = regRdData;
  endtask
  // Counts alignment cycles and output rising edges over a span
  task automatic watch(input int n);
    logic p;
    hiCnt = 0;
    riseCnt = 0;
    repeat (n) begin
      p = outP;
      tick(1);
      hiCnt += aligning;
      riseCnt += (outP && !p);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    {regWrite, regRead, alignRequest, outputOverride, calibrationActive, channel1Clk} = '0;
    {prescalerA, prescalerB, fracDivClk, channel3Clk} = '0;
    regAddr = '0;
    regWrData = '0;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rdv, rows[i].e);
    end
    chk(fracSynthWord, {16'hABCD, 9'h1FF});
    wr(8'h2D, 16'h8071);
    tick(2);
    chk(fracDelayWord, {16'hABCD, 9'h1FF});
    chk(fracSynthWord, 0);
    wr(8'h2D, 16'h0071);
    for (int f = 0; f < 8; f++) begin
      wr(8'h2C, 16'(f << 2));
      tick(2);
      chk(outputFormat, f[2:0]);
      chk({outPEnable, outNEnable}, {f != 0 && f != 7, f != 0 && f != 6});
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h2C, 16'((p << 5) | 16'h0014));
      tick(4);
      chk({outP, outN}, p[1:0]);
    end
    outputOverride = 1'b1;
    wr(8'h2C, 16'h0084);
    tick(2);
    chk({muteActive, outP, outN}, 3'b101);
    wr(8'h2C, 16'h0184);
    tick(2);
    chk({muteActive, outP, outN}, 3'b110);
    outputOverride = 1'b0;
    calibrationActive = 1'b1;
    tick(2);
    chk(muteActive, 1'b1);
    calibrationActive = 1'b0;
    tick(2);
    chk(muteActive, 1'b0);
    wr(8'h2C, 16'h0004);
    channel1Clk = 1'b1;
    tick(8);
    chk(outP, 1'b1);
    wr(8'h2C, 16'h0006);
    tick(2);
    chk(outP, 1'b0);
    channel3Clk = 1'b1;
    tick(8);
    chk(outP, 1'b1);
    wr(8'h2C, 16'h0007);
    tick(2);
    chk(outP, 1'b0);
    wr(8'h2C, 16'h0005);
    wr(8'h2B, 16'hC002);
    tick(8);
    chk(dividerPoweredDown, 1'b0);
    watch(320);
    chk(riseCnt >= 8 && riseCnt <= 11, 1'b1);
    wr(8'h2B, 16'hC000);
    tick(60);
    chk(dividerPoweredDown, 1'b1);
    wr(8'h2B, 16'hC002);
    wr(8'h2C, 16'h1804);
    alignRequest = 1'b1;
    watch(40);
    chk(hiCnt, 0);
    alignRequest = 1'b0;
    wr(8'h2C, 16'h1C04);
    tick(4);
    alignRequest = 1'b1;
    watch(120);
    chk(hiCnt >= 30 && hiCnt <= 60, 1'b1);
    // Immediate mode; divide by one passes the level of the chosen source
    wr(8'h2D, 16'h0070);
    wr(8'h2C, 16'h0005);
    for (int s = 0; s < 3; s++) begin
      {prescalerA, prescalerB, fracDivClk} = 3'b100 >> s;
      wr(8'h2B, 16'((s << 14) | 1));
      tick(8);
      chk(outP, 1'b1);
      chk(dividerPoweredDown, 1'b0);
    end
    rst = 1'b1;
    tick(2);
    chk({dividerPoweredDown, outputFormat}, 4'h8);
    rst = 1'b0;
    tick(2);
    chk(fracSynthWord, 25'h100_0000);
    rd(8'h2C);
    chk(rdv, 16'h0008);
    tally_and_finish;
  end
endmodule // tb
